// ---- design/wdt_pkg.sv ----
/*
 Watchdog package: register offsets, option-byte field positions, service and read-back
 values, reset values and the start-up count.
 Assumes 32-bit AHB-Lite with one aligned word per register.
*/
package wdt_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] KICK_OFFSET = 8'h00;
   localparam logic [7:0] IMS_OFFSET = 8'h04;
   localparam logic [7:0] IXS_OFFSET = 8'h08;
   localparam logic [7:0] CAUSE_OFFSET = 8'h0C;
   localparam logic [7:0] COUNT_OFFSET = 8'h10;
   localparam logic [7:0] OPTION_BYTE_OFFSET = 8'h80;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int OSC_LOCK_BIT = 0;
   localparam int PERIOD_SEL_LSB = 1;
   localparam int RUN_EN_BIT = 4;
   localparam int WINDOW_LOW_BIT = 5;
   localparam int WINDOW_HIGH_BIT = 6;
   localparam int KICK_BITOP_BIT = 8;
   localparam int FLAG_BIT = 4;
   // ----------------------------------------------------------------
   // Values
   // ----------------------------------------------------------------
   localparam logic [7:0] SERVICE_VALUE = 8'hAC;
   localparam logic [7:0] READ_RUN_ON = 8'h9A;
   localparam logic [7:0] READ_RUN_OFF = 8'h1A;
   localparam logic [1:0] WINDOW_FULL = 2'h3;
   localparam logic [15:0] EXEMPT_BASE = 16'hFB00;
   localparam logic [16:0] COUNT_ALL_ONES = 17'h1FFFF;
   localparam logic [2:0] PERIOD_SEL_MAX = 3'h7;
   localparam logic [15:0] IMS_RESET = 16'hC000;
   localparam logic [15:0] IXS_RESET = 16'hF000;
   localparam logic [2:0] BOOT_CYCLES = 3'h4;
   localparam logic HRESP_OKAY = 1'b0;
endpackage : wdt_pkg

// ---- design/pin_sync.sv ----
/*
 Three-stage synchroniser for pins; the output changes once stages two and three agree.
 Assumes a slow, static or debounced input relative to hclk.
*/
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   import wdt_pkg::*;
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_state_t;
   sync_state_t r;
   sync_state_t n;
   always_comb begin
      n = r;
      n.s1 = d;
      n.s2 = r.s1;
      n.s3 = r.s2;
      if (r.s2 == r.s3) begin
         n.q = r.s3;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end
   assign q = r.q;
endmodule : pin_sync

// ---- design/area_check.sv ----
/*
 Address legality check against the configured code and RAM areas.
 Assumes 16-bit CPU addresses; the upper exempt range applies only when asked.
*/
`timescale 1ns/100ps
module area_check (
   input wire logic [15:0] addr,
   input wire logic [15:0] rom_end,
   input wire logic [15:0] ram_start,
   input wire logic exempt_en,
   output logic legal
);
   import wdt_pkg::*;
   assign legal = (addr < rom_end) || (addr >= ram_start) || (exempt_en && addr >= EXEMPT_BASE);
endmodule : area_check

// ---- design/windowed_watchdog.sv ----
/*
 Windowed watchdog with access guard, AHB-Lite register slave, low-speed clock pin
 sampled on hclk.
 Assumes a static option-byte strap, CPU fetch and data strobes on hclk and a
 system reset block that acts on wdt_reset_req.
*/
`timescale 1ns/100ps
module windowed_watchdog (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [7:0] option_byte_pins,
   input wire logic lowspeed_clk_pin,
   input wire logic halt_mode,
   input wire logic stop_mode,
   input wire logic lowspeed_osc_halt,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic data_valid,
   input wire logic [15:0] data_addr,
   output logic wdt_reset_req,
   output logic watchdog_reset_flag
);
   import wdt_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] boot;
      logic opt_valid;
      logic [7:0] opt;
      logic [16:0] count;
      logic ls_prev;
      logic kicked_once;
      logic clr_pend;
      logic err_pend;
      logic flag;
      logic [15:0] internal_memory_size_register;
      logic [15:0] expansion_ram_size_register;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic req;
   } wdt_state_t;

   localparam wdt_state_t STATE_RESET = '{
      boot: 3'h0, opt_valid: 1'b0, opt: 8'h00, count: 17'h00000, ls_prev: 1'b0,
      kicked_once: 1'b0, clr_pend: 1'b0, err_pend: 1'b0, flag: 1'b0,
      internal_memory_size_register: IMS_RESET, expansion_ram_size_register: IXS_RESET, wr_pend: 1'b0, wr_addr: 8'h00,
      rdata: 32'h00000000, req: 1'b0};

   wdt_state_t r;
   wdt_state_t n;

   logic ls_q;
   logic [7:0] opt_q;
   logic fetch_legal;
   logic data_legal;
   logic en;
   logic held;
   logic running;
   logic tick;
   logic take;
   logic kick_wr;
   logic kick_bad;
   logic kick_ok;
   logic overflow_hit;
   logic fetch_bad;
   logic data_bad;
   logic req_now;
   logic window_open;
   logic [2:0] period_sel;
   logic [16:0] last_count;
   logic [31:0] rd;

   // ----------------------------------------------------------------
   // Pin synchronisers and area checks
   // ----------------------------------------------------------------
   pin_sync #(.W(1)) u_ls_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .d(lowspeed_clk_pin),
      .q(ls_q)
   );

   pin_sync #(.W(8)) u_opt_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .d(option_byte_pins),
      .q(opt_q)
   );

   area_check u_fetch_check (
      .addr(fetch_addr),
      .rom_end(r.internal_memory_size_register),
      .ram_start(r.expansion_ram_size_register),
      .exempt_en(1'b0),
      .legal(fetch_legal)
   );

   area_check u_data_check (
      .addr(data_addr),
      .rom_end(r.internal_memory_size_register),
      .ram_start(r.expansion_ram_size_register),
      .exempt_en(1'b1),
      .legal(data_legal)
   );

   // ----------------------------------------------------------------
   // Decode of mode and events
   // ----------------------------------------------------------------
   always_comb begin
      en = r.opt_valid && r.opt[RUN_EN_BIT];
      held = !r.opt[OSC_LOCK_BIT] && (halt_mode || stop_mode || lowspeed_osc_halt);
      running = en && !held;
      tick = ls_q && !r.ls_prev;
      window_open = {r.opt[WINDOW_HIGH_BIT], r.opt[WINDOW_LOW_BIT]} == WINDOW_FULL;
      period_sel = r.opt[PERIOD_SEL_LSB +: 3];
      last_count = COUNT_ALL_ONES >> (PERIOD_SEL_MAX - period_sel);
      take = hsel && hready && htrans[1];
      kick_wr = r.wr_pend && (r.wr_addr == KICK_OFFSET);
      kick_bad = kick_wr && (hwdata[KICK_BITOP_BIT]
         || (hwdata[7:0] != SERVICE_VALUE)
         || (r.kicked_once && !window_open));
      kick_ok = kick_wr && !kick_bad;
      overflow_hit = running && tick && !r.clr_pend && (r.count == last_count);
      fetch_bad = en && fetch_valid && !fetch_legal;
      data_bad = en && data_valid && !data_legal;
      req_now = overflow_hit || fetch_bad || data_bad
         || (running && (kick_bad || r.err_pend));
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb begin
      rd = 32'h00000000;
      unique case (haddr[7:0])
         KICK_OFFSET: rd = {24'h000000, en ? READ_RUN_ON : READ_RUN_OFF};
         IMS_OFFSET: rd = {16'h0000, r.internal_memory_size_register};
         IXS_OFFSET: rd = {16'h0000, r.expansion_ram_size_register};
         CAUSE_OFFSET: rd = {27'h0000000, r.flag, 4'h0};
         COUNT_OFFSET: rd = {15'h0000, r.count};
         OPTION_BYTE_OFFSET: rd = {24'h000000, r.opt};
         default: rd = 32'h00000000;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n = r;
      n.req = 1'b0;
      n.ls_prev = ls_q;
      if (!r.opt_valid) begin
         if (r.boot == BOOT_CYCLES) begin
            n.opt = opt_q;
            n.opt_valid = 1'b1;
         end else begin
            n.boot = r.boot + 3'h1;
         end
      end
      n.wr_pend = take && hwrite;
      if (take) begin
         n.wr_addr = haddr[7:0];
      end
      if (take && !hwrite) begin
         n.rdata = rd;
         if (haddr[7:0] == CAUSE_OFFSET) begin
            n.flag = 1'b0;
         end
      end
      if (r.wr_pend && r.wr_addr == IMS_OFFSET) begin
         n.internal_memory_size_register = hwdata[15:0];
      end
      if (r.wr_pend && r.wr_addr == IXS_OFFSET) begin
         n.expansion_ram_size_register = hwdata[15:0];
      end
      if (running && tick) begin
         if (r.clr_pend) begin
            n.count = 17'h00000;
            n.clr_pend = 1'b0;
         end else if (r.count != last_count) begin
            n.count = r.count + 17'h00001;
         end
      end
      if (en && kick_ok) begin
         n.clr_pend = 1'b1;
         n.kicked_once = 1'b1;
      end
      if (en && kick_bad && !running) begin
         n.err_pend = 1'b1;
      end
      if (req_now) begin
         n.req = 1'b1;
         n.count = 17'h00000;
         n.clr_pend = 1'b0;
         n.err_pend = 1'b0;
         n.kicked_once = 1'b0;
         n.flag = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= STATE_RESET;
      end else if (ce) begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign hreadyout = ce;
   assign hresp = HRESP_OKAY;
   assign hrdata = r.rdata;
   assign wdt_reset_req = r.req;
   assign watchdog_reset_flag = r.flag;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn || !ce);

   disabled_quiet_a: assert property (r.opt_valid && !r.opt[RUN_EN_BIT] |-> r.count == 17'h00000)
      else $error("counter moved while run enable is off");
   no_detect_off_a: assert property (!en && !r.err_pend |=> !wdt_reset_req)
      else $error("reset request while detection disabled");
   count_step_a: assert property (running && tick && !r.clr_pend && !req_now
      && r.count != last_count |=> r.count == $past(r.count) + 17'h00001)
      else $error("counter failed to advance on low-speed tick");
   kick_set_a: assert property (en && kick_ok && !req_now |=> r.clr_pend)
      else $error("service write set no pending clear");
   kick_clear_a: assert property (r.clr_pend && running && tick && !req_now
      |=> r.count == 17'h00000)
      else $error("pending clear did not zero the counter");
   bad_kick_a: assert property (running && kick_bad |=> wdt_reset_req)
      else $error("bad kick write gave no reset");
   bitop_kick_a: assert property (running && kick_wr && hwdata[KICK_BITOP_BIT] |=> wdt_reset_req)
      else $error("bit manipulation on kick gave no reset");
   closed_window_a: assert property (running && kick_wr && r.kicked_once && !window_open
      |=> wdt_reset_req && watchdog_reset_flag)
      else $error("kick in closed window gave no reset");
   overflow_reset_a: assert property (overflow_hit |=> wdt_reset_req ##1 r.count == 17'h00000)
      else $error("overflow gave no reset");
   fetch_guard_a: assert property (en && fetch_valid && !fetch_legal |=> wdt_reset_req)
      else $error("illegal fetch gave no reset");
   data_exempt_a: assert property (data_valid && data_addr >= EXEMPT_BASE && !fetch_bad
      && !overflow_hit && !(running && (kick_bad || r.err_pend)) |=> !wdt_reset_req)
      else $error("exempt data access caused reset");
   held_count_a: assert property (en && held |=> $stable(r.count) || wdt_reset_req)
      else $error("counter changed while held");
   read_back_a: assert property (take && !hwrite && haddr[7:0] == KICK_OFFSET
      |=> hrdata[7:0] == ($past(en) ? READ_RUN_ON : READ_RUN_OFF))
      else $error("kick register read-back value wrong");
   req_zero_a: assert property (wdt_reset_req |-> r.count == 17'h00000 && watchdog_reset_flag)
      else $error("reset request left counter or flag wrong");
   first_kick_a: assert property (en && kick_wr && !r.kicked_once && !req_now
      && hwdata[7:0] == SERVICE_VALUE && !hwdata[KICK_BITOP_BIT] |=> r.kicked_once)
      else $error("first service write not accepted");
   held_err_a: assert property (en && !running && kick_bad
      |=> r.err_pend || wdt_reset_req)
      else $error("bad kick while held was not remembered");
   err_fire_a: assert property (running && r.err_pend |=> wdt_reset_req)
      else $error("remembered bad kick gave no reset");
   lock_runs_a: assert property (en && r.opt[OSC_LOCK_BIT] |-> running)
      else $error("locked oscillator did not keep counting");
   count_frozen_a: assert property (!(running && tick) && !req_now
      |=> $stable(r.count))
      else $error("counter moved without a low-speed tick");
   count_limit_a: assert property (r.count <= last_count)
      else $error("counter passed its overflow value");
   period_span_a: assert property (r.opt_valid
      |-> ({1'b0, last_count} + 18'h00001) == (18'h00400 << period_sel))
      else $error("overflow period does not match selector");
   flag_set_a: assert property (req_now |=> watchdog_reset_flag)
      else $error("reset request did not set the flag");
   flag_keep_a: assert property (watchdog_reset_flag
      && !(take && !hwrite && haddr[7:0] == CAUSE_OFFSET) |=> watchdog_reset_flag)
      else $error("reset flag lost without a cause read");
   cause_clear_a: assert property (take && !hwrite && haddr[7:0] == CAUSE_OFFSET && !req_now
      |=> !watchdog_reset_flag)
      else $error("cause read did not clear the flag");
   area_write_a: assert property (r.wr_pend && r.wr_addr == IMS_OFFSET
      |=> r.internal_memory_size_register == $past(hwdata[15:0]))
      else $error("memory-size write lost");
   ram_write_a: assert property (r.wr_pend && r.wr_addr == IXS_OFFSET
      |=> r.expansion_ram_size_register == $past(hwdata[15:0]))
      else $error("expansion size write lost");
   opt_static_a: assert property (r.opt_valid |=> $stable(r.opt))
      else $error("option byte changed after capture");
   no_early_req_a: assert property (!r.opt_valid |=> !wdt_reset_req)
      else $error("reset request before option byte capture");

   // ----------------------------------------------------------------
   // Cover properties
   // ----------------------------------------------------------------
   kick_seen_c: cover property (en && kick_ok ##[1:200] r.count == 17'h00000);
   overflow_seen_c: cover property (overflow_hit ##1 wdt_reset_req);
   fetch_seen_c: cover property (fetch_bad ##1 wdt_reset_req);
   data_seen_c: cover property (data_bad ##1 wdt_reset_req);
   held_seen_c: cover property (en && held ##1 !held);
endmodule : windowed_watchdog

// ---- bench/cpu_core_model.sv ----
/*
 CPU core and low-speed oscillator model: a free-running low-speed clock and fetch or
 data strobes, one per acc_req pulse.
 Assumes acc_req is driven on the rising edge of hclk.
*/
`timescale 1ns/100ps
module cpu_core_model (
   input wire logic hclk,
   input wire logic acc_req,
   input wire logic acc_fetch,
   input wire logic [15:0] acc_addr,
   output logic lowspeed_clk_pin,
   output logic fetch_valid,
   output logic [15:0] fetch_addr,
   output logic data_valid,
   output logic [15:0] data_addr
);
   logic [1:0] div;
   initial begin
      div = 2'h0;
      lowspeed_clk_pin = 1'b0;
      fetch_valid = 1'b0;
      data_valid = 1'b0;
      fetch_addr = 16'h0000;
      data_addr = 16'h0000;
   end
   // ----------------------------------------------------------------
   // Oscillator and access strobes
   // ----------------------------------------------------------------
   always @(posedge hclk) begin
      div <= div + 2'h1;
      if (div == 2'h3) lowspeed_clk_pin <= ~lowspeed_clk_pin;
      fetch_valid <= acc_req & acc_fetch;
      data_valid <= acc_req & ~acc_fetch;
      // Idle address lines change every cycle
      fetch_addr <= (acc_req & acc_fetch) ? acc_addr : ~fetch_addr;
      data_addr <= (acc_req & ~acc_fetch) ? acc_addr : ~data_addr;
   end
endmodule : cpu_core_model

// ---- bench/windowed_watchdog_with_access_guard_test.sv ----
/*
 Self-checking bench for the windowed watchdog: AHB-Lite master tasks and scenarios.
 Assumes zero-wait-state slave and the cpu_core_model at the far side.
*/
`timescale 1ns/100ps
module windowed_watchdog_with_access_guard_test;
   import wdt_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, c1;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, wdt_reset_req, watchdog_reset_flag;
   logic [7:0] option_byte_pins = 8'h70;
   logic halt_mode = 1'b0, stop_mode = 1'b0, lowspeed_osc_halt = 1'b0;
   logic lsclk, fv, dv, acc_req = 1'b0, acc_fetch = 1'b0;
   logic [15:0] fa, da, acc_addr = 16'h0;
   int mismatches = 0, n_tests = 0, n_rst = 0, cyc = 0, r0;
   assign hready = hreadyout;
   always #25 hclk = ~hclk;
   windowed_watchdog u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .option_byte_pins(option_byte_pins), .lowspeed_clk_pin(lsclk), .halt_mode(halt_mode),
      .stop_mode(stop_mode), .lowspeed_osc_halt(lowspeed_osc_halt), .fetch_valid(fv),
      .fetch_addr(fa), .data_valid(dv), .data_addr(da), .wdt_reset_req(wdt_reset_req),
      .watchdog_reset_flag(watchdog_reset_flag));
   cpu_core_model u_cpu (.hclk(hclk), .acc_req(acc_req), .acc_fetch(acc_fetch),
      .acc_addr(acc_addr), .lowspeed_clk_pin(lsclk), .fetch_valid(fv), .fetch_addr(fa),
      .data_valid(dv), .data_addr(da));
   // ----------------------------------------------------------------
   // Monitors and verdict
   // ----------------------------------------------------------------
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (wdt_reset_req === 1'b1) n_rst <= n_rst + 1;
      if (cyc == 60000) begin
         mismatches = mismatches + 1;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   // ----------------------------------------------------------------
   // Bus, reset and access tasks
   // ----------------------------------------------------------------
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic do_reset(input logic [7:0] opt);
      @(posedge hclk);
      hresetn <= 1'b0;
      option_byte_pins <= opt;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (12) @(posedge hclk);
   endtask : do_reset
   task automatic access(input logic f, input logic [15:0] a, input int exp);
      r0 = n_rst;
      @(posedge hclk);
      acc_req <= 1'b1;
      acc_fetch <= f;
      acc_addr <= a;
      @(posedge hclk);
      acc_req <= 1'b0;
      repeat (4) @(posedge hclk);
      check("access_reset", exp, n_rst - r0);
   endtask : access
   task automatic kick(input logic [31:0] v, input int exp);
      r0 = n_rst;
      ahb(1'b1, KICK_OFFSET, v);
      repeat (3) @(posedge hclk);
      check("kick_reset", exp, n_rst - r0);
   endtask : kick
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs_and_kicks();
      do_reset(8'h70);
      ahb(1'b0, KICK_OFFSET, 0);
      check("kick_read", READ_RUN_ON, rd);
      ahb(1'b0, OPTION_BYTE_OFFSET, 0);
      check("option_byte", 32'h70, rd);
      ahb(1'b0, 8'h40, 0);
      check("unmapped", 32'h0, rd);
      ahb(1'b0, COUNT_OFFSET, 0);
      check("count_runs", 1, rd > 0);
      kick(SERVICE_VALUE, 0);
      kick(SERVICE_VALUE, 0);
      repeat (16) @(posedge hclk);
      ahb(1'b0, COUNT_OFFSET, 0);
      check("count_cleared", 1, rd < 4);
      kick(32'h100 | SERVICE_VALUE, 1);
      kick(32'h55, 1);
   endtask : t_regs_and_kicks
   task automatic t_overflow();
      do_reset(8'h70);
      r0 = n_rst;
      repeat (7500) @(posedge hclk);
      check("no_early_ovf", 0, n_rst - r0);
      repeat (1500) @(posedge hclk);
      check("overflow", 1, n_rst - r0);
      check("flag", 1'b1, watchdog_reset_flag);
      ahb(1'b0, COUNT_OFFSET, 0);
      check("count_zeroed", 1, rd < 130);
      ahb(1'b0, CAUSE_OFFSET, 0);
      check("cause_set", 32'h10, rd & 32'h10);
      ahb(1'b0, CAUSE_OFFSET, 0);
      check("cause_clear", 32'h0, rd & 32'h10);
   endtask : t_overflow
   task automatic t_hold(input logic [7:0] opt, input logic exp_move);
      do_reset(opt);
      for (int m = 0; m < 3; m++) begin
         @(posedge hclk);
         halt_mode <= (m == 0);
         stop_mode <= (m == 1);
         lowspeed_osc_halt <= (m == 2);
         repeat (10) @(posedge hclk);
         ahb(1'b0, COUNT_OFFSET, 0);
         c1 = rd;
         repeat (200) @(posedge hclk);
         ahb(1'b0, COUNT_OFFSET, 0);
         check("count_moves_low_power", exp_move, rd != c1);
         halt_mode <= 1'b0;
         stop_mode <= 1'b0;
         lowspeed_osc_halt <= 1'b0;
         repeat (40) @(posedge hclk);
         ahb(1'b0, COUNT_OFFSET, 0);
         check("count_resumes", 1, rd > c1 && rd < c1 + 40);
      end
   endtask : t_hold
   initial begin
      repeat (3) @(posedge hclk);
      t_regs_and_kicks();
      access(1'b1, 16'hBFFF, 0);
      access(1'b1, 16'hC000, 1);
      access(1'b0, 16'hF000, 0);
      access(1'b0, 16'hFB00, 0);
      access(1'b0, 16'hC000, 1);
      ahb(1'b1, IXS_OFFSET, 32'hFF00);
      ahb(1'b0, IXS_OFFSET, 0);
      check("ixs_write", 32'hFF00, rd);
      access(1'b0, 16'hFB00, 0);
      access(1'b1, 16'hFB00, 1);
      do_reset(8'h30);
      kick(SERVICE_VALUE, 0);
      kick(SERVICE_VALUE, 1);
      t_overflow();
      t_hold(8'h70, 1'b0);
      t_hold(8'h71, 1'b1);
      do_reset(8'h60);
      ahb(1'b0, KICK_OFFSET, 0);
      check("kick_read_off", READ_RUN_OFF, rd);
      access(1'b1, 16'hC000, 0);
      ahb(1'b0, COUNT_OFFSET, 0);
      check("count_off", 32'h0, rd);
      print_verdict();
   end
endmodule : windowed_watchdog_with_access_guard_test
